/* verilog/otal_alert.sv */
/*
 * Overtemperature alert output logic: limit registers, mode control,
 * consecutive-fault counting and the open-drain alert pin.
 * Assumes measurements arrive as one-cycle valid pulses on sys_clk and
 * that the register port obeys the one-cycle strobe protocol.
 */
// The register addresses and the plain strobed port are this design's own decisions.
// What this block does
// - Alert pin has overtemperature and bus-alert modes.
// - Overtemperature mode is selected after reset.
// - Comparator and interrupt sub-modes; comparator at reset.
// - Comparator: assert when temperature reaches limit.
// - Comparator: release only below hysteresis limit.
// - Shutdown leaves comparator alert state untouched.
// - Interrupt: assert after enough consecutive faults.
// - Interrupt: any register read clears alert.
// - After clear, reassert only on new fault.
// - Limits are signed two's complement values.
// - Overtemperature limit resets to +80 degrees.
`timescale 1ns/1ps
module otal_alert #(
    parameter int QUEUE_W = 2
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire otal_pkg::otal_meas_t meas,
    input wire otal_pkg::otal_bus_req_t bus_req,
    output logic [otal_pkg::OTAL_DW-1:0] rdata,
    input wire logic overtemp_alert_output_i,
    output logic overtemp_alert_output_o,
    output logic overtemp_alert_output_oe
);
    import otal_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] cfg_reg;
    logic [15:0] limit_reg;
    logic [15:0] hyst_reg;
    logic [15:0] temp_reg;
    logic [2:0] fault_reg;
    logic alert_reg;
    logic [15:0] rdata_reg;
    logic shutdown;
    logic latched_mode;
    logic pol_high;
    logic [2:0] required;
    logic take;
    logic hot;
    logic cool;
    logic trip;

    // Signed comparison used by both the trip and release checks.
    function automatic logic sgte(input logic [15:0] a, input logic [15:0] b);
        return $signed(a) >= $signed(b);
    endfunction

    // Decoded configuration and measurement qualifiers.
    assign shutdown = cfg_reg[OTAL_CFG_SHUTDOWN];
    assign latched_mode = cfg_reg[OTAL_CFG_INT_MODE] | cfg_reg[OTAL_CFG_SMB_MODE];
    assign pol_high = cfg_reg[OTAL_CFG_POL_HIGH];
    assign required = 3'({1'b0, cfg_reg[OTAL_CFG_QUEUE_LO +: QUEUE_W]}) + 3'h1;
    assign take = ce & meas.valid & ~shutdown;
    assign hot = sgte(meas.temp, limit_reg);
    assign cool = ~sgte(meas.temp, hyst_reg);
    assign trip = take & hot & (fault_reg + 3'h1 >= required);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Software-written registers; reset selects comparator, overtemp mode.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_reg <= OTAL_CFG_RST;
            limit_reg <= OTAL_LIMIT_RST;
            hyst_reg <= OTAL_HYST_RST;
        end else if (ce && bus_req.wr) begin
            unique case (bus_req.addr)
                OTAL_ADDR_CFG: cfg_reg <= bus_req.wdata[7:0];
                OTAL_ADDR_HYST: hyst_reg <= bus_req.wdata;
                OTAL_ADDR_LIMIT: limit_reg <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // Last accepted measurement.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            temp_reg <= OTAL_TEMP_RST;
        end else if (take) begin
            temp_reg <= meas.temp;
        end
    end

    // ------------------------------------------------------------------
    // Fault counting and alert state
    // ------------------------------------------------------------------
    // Consecutive faults; any passing measurement restarts the count.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fault_reg <= OTAL_FAULT_RST;
        end else if (take) begin
            if (!hot) begin
                fault_reg <= OTAL_FAULT_RST;
            end else if (fault_reg < required) begin
                fault_reg <= fault_reg + 3'h1;
            end
        end
    end

    // Alert state; a new trip wins over a read clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            alert_reg <= 1'b0;
        end else if (ce) begin
            if (!latched_mode) begin
                if (take && hot) begin
                    alert_reg <= 1'b1;
                end else if (take && cool) begin
                    alert_reg <= 1'b0;
                end
            end else if (trip) begin
                alert_reg <= 1'b1;
            end else if (bus_req.rd) begin
                alert_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port and pin
    // ------------------------------------------------------------------
    // Read data stand in the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_reg <= 16'h0000;
        end else if (ce) begin
            rdata_reg <= 16'h0000;
            if (bus_req.rd) begin
                unique case (bus_req.addr)
                    OTAL_ADDR_TEMP: rdata_reg <= temp_reg;
                    OTAL_ADDR_CFG: rdata_reg <= {8'h00, cfg_reg};
                    OTAL_ADDR_HYST: rdata_reg <= hyst_reg;
                    OTAL_ADDR_LIMIT: rdata_reg <= limit_reg;
                    OTAL_ADDR_STATUS: rdata_reg <= {11'h000, fault_reg,
                        overtemp_alert_output_i, alert_reg};
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end
    assign rdata = rdata_reg;

    // Open-drain pin: pulled low while alert_reg differs from pol_high.
    assign overtemp_alert_output_o = 1'b0;
    assign overtemp_alert_output_oe = alert_reg ^ pol_high;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_hot_meas;
        ce && meas.valid && !shutdown && sgte(meas.temp, limit_reg);
    endsequence

    sequence s_cool_meas;
        ce && meas.valid && !shutdown && !sgte(meas.temp, hyst_reg)
            && !sgte(meas.temp, limit_reg);
    endsequence

    a_limit_reset_value: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> limit_reg == 16'h5000 && cfg_reg == 8'h00)
        else $error("Limit or mode not at reset value.");

    a_cmp_trip_now: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!latched_mode && !bus_req.wr) ##0 s_hot_meas |=> alert_reg)
        else $error("Comparator did not assert on hot measurement.");

    a_cmp_release_cool: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!latched_mode && !bus_req.wr) ##0 s_cool_meas |=> !alert_reg)
        else $error("Comparator did not release below hysteresis.");

    a_cmp_hold_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !latched_mode && !bus_req.wr && alert_reg
            && !(meas.valid && !shutdown && !sgte(meas.temp, hyst_reg)) |=> alert_reg)
        else $error("Comparator alert dropped above hysteresis.");

    a_shutdown_keeps_state: assert property (@(posedge sys_clk) disable iff (sys_rst)
        shutdown && !latched_mode && !bus_req.wr |=> $stable(alert_reg))
        else $error("Shutdown changed comparator alert.");

    a_int_needs_queue: assert property (@(posedge sys_clk) disable iff (sys_rst)
        latched_mode && !bus_req.wr && !alert_reg && ce
            && (fault_reg + 3'h1 < required) |=> !alert_reg)
        else $error("Interrupt asserted before enough faults.");

    a_int_read_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        latched_mode && !bus_req.wr && ce && bus_req.rd && !trip ##1 !bus_req.wr
            |-> !alert_reg)
        else $error("Register read did not clear interrupt.");

    a_int_no_rearm: assert property (@(posedge sys_clk) disable iff (sys_rst)
        latched_mode && !bus_req.wr && !alert_reg && !(ce && meas.valid) |=> !alert_reg)
        else $error("Interrupt reasserted without a measurement.");

    a_queue_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
        take && !hot |=> fault_reg == 3'h0)
        else $error("Fault count not restarted on pass.");

    a_pin_polarity: assert property (@(posedge sys_clk) disable iff (sys_rst)
        overtemp_alert_output_oe == (alert_reg != pol_high) && !overtemp_alert_output_o)
        else $error("Pin drive does not match polarity.");

    a_int_trip_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
        latched_mode && trip |=> alert_reg)
        else $error("Interrupt not raised after enough faults.");

    a_ce_freezes_state: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ce |=> $stable(alert_reg) && $stable(fault_reg) && $stable(cfg_reg))
        else $error("State moved while the clock enable was low.");

    a_pin_reset_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> !overtemp_alert_output_oe)
        else $error("Alert pin driven right after reset.");

endmodule

/* verilog/otal_pkg.sv */
/*
 * Constants and carrier types for the overtemperature alert output logic.
 * Assumes a single 25 MHz clock and a plain register port on the same clock.
 */
package otal_pkg;

    // ------------------------------------------------------------------
    // Register map and widths
    // ------------------------------------------------------------------
    localparam int OTAL_AW = 3;
    localparam int OTAL_DW = 16;
    localparam logic [2:0] OTAL_ADDR_TEMP = 3'h0;
    localparam logic [2:0] OTAL_ADDR_CFG = 3'h1;
    localparam logic [2:0] OTAL_ADDR_HYST = 3'h2;
    localparam logic [2:0] OTAL_ADDR_LIMIT = 3'h3;
    localparam logic [2:0] OTAL_ADDR_STATUS = 3'h4;

    // ------------------------------------------------------------------
    // Configuration field positions and reset values
    // ------------------------------------------------------------------
    localparam int OTAL_CFG_SHUTDOWN = 0;
    localparam int OTAL_CFG_INT_MODE = 1;
    localparam int OTAL_CFG_POL_HIGH = 2;
    localparam int OTAL_CFG_QUEUE_LO = 3;
    localparam int OTAL_CFG_QUEUE_HI = 4;
    localparam int OTAL_CFG_SMB_MODE = 5;
    localparam logic [7:0] OTAL_CFG_RST = 8'h00;
    localparam logic [15:0] OTAL_LIMIT_RST = 16'h5000;
    localparam logic [15:0] OTAL_HYST_RST = 16'h4b00;
    localparam logic [15:0] OTAL_TEMP_RST = 16'h0000;
    localparam logic [2:0] OTAL_FAULT_RST = 3'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [15:0] temp;
    } otal_meas_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [15:0] wdata;
    } otal_bus_req_t;

endpackage

/* verification/otal_host_model.sv */
/*
 * Host-side model of the open-drain alert line and its pull-up.
 * Assumes the device pulls the line only while its enable is high.
 */
`timescale 1ns/1ps
module otal_host_model (
    input wire logic oe,
    input wire logic o,
    output logic pin
);
    // The pull-up wins whenever the device lets go of the line.
    assign pin = oe ? o : 1'b1;
endmodule

/* verification/overtemp_alert_output_logic_tb.sv */
/*
 * Self-checking bench for the alert logic, random and directed stimulus.
 * Assumes the host model resolves the open-drain alert line.
 */
`timescale 1ns/1ps
module overtemp_alert_output_logic_tb;
    import otal_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    otal_meas_t meas = '0;
    otal_bus_req_t bus_req = '0;
    logic [15:0] rdata;
    logic [15:0] t;
    logic pin, o, oe, a;
    logic ce = 1'b1;
    int n_errors = 0;
    int num_checks = 0;
    integer seed = 32'he234d223;

    otal_alert u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .meas(meas),
        .bus_req(bus_req), .rdata(rdata), .overtemp_alert_output_i(pin),
        .overtemp_alert_output_o(o), .overtemp_alert_output_oe(oe));
    otal_host_model u_host (.oe(oe), .o(o), .pin(pin));

    // Free-running 25 MHz clock.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Checks, bus cycles and the expected comparator state
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] ad, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] ad, input logic [15:0] e, input logic [15:0] m);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 16'h0000};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk("rdata", e, rdata & m);
    endtask
    task automatic ms(input logic [15:0] tv, input logic e);
        @(posedge sys_clk);
        meas <= '{valid: 1'b1, temp: tv};
        @(posedge sys_clk);
        meas.valid <= 1'b0;
        #1;
        chk("oe", {15'h0000, e}, {15'h0000, oe});
    endtask
    // Comparator behaviour with signed limits; a trip beats a release.
    function automatic logic cmp(input logic al, input logic [15:0] tv,
        input logic [15:0] lim, input logic [15:0] hy);
        if ($signed(tv) >= $signed(lim)) begin
            return 1'b1;
        end
        if ($signed(tv) < $signed(hy)) begin
            return 1'b0;
        end
        return al;
    endfunction
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk("oe", 16'h0000, {15'h0000, oe});
        chk("o", 16'h0000, {15'h0000, o});
        rd(OTAL_ADDR_CFG, 16'h0000, 16'hffff);
        rd(OTAL_ADDR_LIMIT, 16'h5000, 16'hffff);
        rd(OTAL_ADDR_HYST, 16'h4b00, 16'hffff);
        ms(16'h5000, 1'b1);
        ms(16'h4b00, 1'b1);
        ms(16'h4aff, 1'b0);
        ms(16'h5001, 1'b1);
        wr(OTAL_ADDR_CFG, 16'h0001);
        ms(16'h0000, 1'b1);
        rd(OTAL_ADDR_STATUS, 16'h0001, 16'h0003);
        wr(OTAL_ADDR_CFG, 16'h0000);
        ms(16'h0000, 1'b0);
        // A hot measurement while the clock enable is low must be ignored.
        @(posedge sys_clk);
        ce <= 1'b0;
        ms(16'h7000, 1'b0);
        @(posedge sys_clk);
        ce <= 1'b1;
        // Random temperatures straddling zero around a negative limit.
        wr(OTAL_ADDR_LIMIT, 16'hff00);
        wr(OTAL_ADDR_HYST, 16'hfe00);
        a = 1'b0;
        for (int i = 0; i < 60; i++) begin
            t = 16'hfd00 + 16'($random(seed) & 32'h03ff);
            a = cmp(a, t, 16'hff00, 16'hfe00);
            ms(t, a);
        end
        wr(OTAL_ADDR_CFG, 16'h0004);
        ms(16'h0100, 1'b0);
        ms(16'h8000, 1'b1);
        // Latched mode needing two consecutive faults.
        wr(OTAL_ADDR_CFG, 16'h000a);
        ms(16'h0100, 1'b0);
        ms(16'h8000, 1'b0);
        ms(16'h0100, 1'b0);
        ms(16'h0100, 1'b1);
        wr(OTAL_ADDR_TEMP, 16'h1234);
        #1;
        chk("oe", 16'h0001, {15'h0000, oe});
        rd(OTAL_ADDR_TEMP, 16'h0100, 16'hffff);
        chk("oe", 16'h0000, {15'h0000, oe});
        repeat (5) @(posedge sys_clk);
        chk("oe", 16'h0000, {15'h0000, oe});
        ms(16'h0100, 1'b1);
        rd(OTAL_ADDR_LIMIT, 16'hff00, 16'hffff);
        chk("oe", 16'h0000, {15'h0000, oe});
        rd(3'h7, 16'h0000, 16'hffff);
        wr(OTAL_ADDR_CFG, 16'h0020);
        ms(16'h0100, 1'b1);
        rd(OTAL_ADDR_CFG, 16'h0020, 16'hffff);
        chk("oe", 16'h0000, {15'h0000, oe});
        rd(OTAL_ADDR_STATUS, 16'h000a, 16'h001f);
        complete_run();
    end
endmodule
